// [hw/frvmf_follower.sv]
// Frame rate follower that keeps the display core locked to the host
//
// Behaviour
// - Continuously measure host sync frame rate; switch output format on change.
// - Any 60 Hz host mode is output as progressive 640x480 at 60 Hz.
// - Any 50 Hz host mode is output as 4:3 768x576 at 50 Hz.
// - Format chosen from frame rate only; monitor identification data never read.
// - Display core takes the new scan rate within 10 us of a change.
// - Output may blank for about 2 s while the back end settles.
// - Steer a loop so the regenerated clock is coherent with 21.477 MHz.
// - Display core shares host clock, reset and start event.
`timescale 1ns/1ps
`default_nettype none

module frvmf_follower
  import frvmf_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = frvmf_pkg::BLANK_CYC,
  parameter logic [frvmf_pkg::PER_W-1:0] PER60_CYC  = frvmf_pkg::PER60,
  parameter logic [frvmf_pkg::PER_W-1:0] PER50_CYC  = frvmf_pkg::PER50,
  parameter logic [frvmf_pkg::PER_W-1:0] PERMIN_CYC = frvmf_pkg::PER_MIN
)
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        host_vsync,
  input  wire logic                        host_reset_n,
  output logic                             fmt_60_q,
  output logic [frvmf_pkg::GEO_W-1:0]      h_active_q,
  output logic [frvmf_pkg::GEO_W-1:0]      v_active_q,
  output logic                             core_rate_60_q,
  output logic                             core_reset_n_q,
  output logic                             core_start_q,
  output logic                             blank_q,
  output logic                             pll_up_q,
  output logic                             pll_dn_q,
  output logic                             pll_lock_q
);
  import frvmf_pkg::*;

  localparam logic [PER_W:0]   PER_SUM     = {1'b0, PER60_CYC} + PER50_CYC;
  localparam logic [PER_W-1:0] PER_MID_CYC = PER_SUM[PER_W:1];

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic              vs_meta_q;
  logic              vs_sync_q;
  logic              vs_prev_q;
  logic              hr_meta_q;
  logic              hr_sync_q;
  logic              hr_prev_q;
  logic              vs_edge;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vs_meta_q <= 1'b0;
      vs_sync_q <= 1'b0;
      vs_prev_q <= 1'b0;
      hr_meta_q <= 1'b0;
      hr_sync_q <= 1'b0;
      hr_prev_q <= 1'b0;
    end
    else
    begin
      vs_meta_q <= host_vsync;
      vs_sync_q <= vs_meta_q;
      vs_prev_q <= vs_sync_q;
      hr_meta_q <= host_reset_n;
      hr_sync_q <= hr_meta_q;
      hr_prev_q <= hr_sync_q;
    end
  end

  assign vs_edge = vs_sync_q && !vs_prev_q;

  // ***********************************************************
  // Frame period measurement
  // ***********************************************************
  logic [PER_W-1:0]  per_cnt_q;
  logic [PER_W-1:0]  per_d;
  logic              per_ok;
  logic              meas_60;

  // Sync glitches shorter than a plausible frame give no rate but restart the period count and the two-frame match
  function automatic logic is_60(input logic [PER_W-1:0] per);
    return per < PER_MID_CYC;
  endfunction

  assign per_ok  = (per_cnt_q >= PERMIN_CYC) && (per_cnt_q != PER_MAX);
  assign meas_60 = is_60(per_cnt_q);
  assign per_d   = (per_cnt_q == PER_MAX) ? PER_MAX : per_cnt_q + 1'b1;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      per_cnt_q <= '0;
    else if (vs_edge)
      per_cnt_q <= '0;
    else
      per_cnt_q <= per_d;
  end

  // ***********************************************************
  // Rate decision
  // ***********************************************************
  logic              cand_60_q;
  logic              cand_seen_q;
  logic              fmt_change;

  // Two matching frames needed; one odd frame never moves the format
  assign fmt_change = vs_edge && per_ok && cand_seen_q
                      && (cand_60_q == meas_60) && (meas_60 != fmt_60_q);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cand_60_q   <= 1'b1;
      cand_seen_q <= 1'b0;
    end
    else if (vs_edge)
    begin
      cand_60_q   <= meas_60;
      cand_seen_q <= per_ok;
    end
  end

  // Decision uses only the measured host rate; no monitor data path
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fmt_60_q <= 1'b1;
    else if (fmt_change)
      fmt_60_q <= meas_60;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_active_q <= H60;
      v_active_q <= V60;
    end
    else if (fmt_60_q)
    begin
      h_active_q <= H60;
      v_active_q <= V60;
    end
    else
    begin
      h_active_q <= H50;
      v_active_q <= V50;
    end
  end

  // Core follows one cycle after the decision, far inside the limit
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      core_rate_60_q <= 1'b1;
    else
      core_rate_60_q <= fmt_60_q;
  end

  // ***********************************************************
  // Back end settle blanking
  // ***********************************************************
  logic [BLK_W-1:0]  blk_cnt_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      blk_cnt_q <= '0;
    else if (fmt_change)
      blk_cnt_q <= BLK_W'(BLANK_CYCLES);
    else if (blk_cnt_q != '0)
      blk_cnt_q <= blk_cnt_q - 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      blank_q <= 1'b0;
    else
      blank_q <= fmt_change || (blk_cnt_q > BLK_W'(1));
  end

  // ***********************************************************
  // Frequency steering for the regenerating loop
  // ***********************************************************
  logic [PER_W-1:0]  nom;

  assign nom = fmt_60_q ? PER60_CYC : PER50_CYC;

  // A frame too long means the local clock runs fast against the host
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_up_q   <= 1'b0;
      pll_dn_q   <= 1'b0;
      pll_lock_q <= 1'b0;
    end
    else if (vs_edge && per_ok)
    begin
      pll_dn_q   <= per_cnt_q > nom + PLL_TOL;
      pll_up_q   <= per_cnt_q + PLL_TOL < nom;
      pll_lock_q <= (per_cnt_q <= nom + PLL_TOL)
                    && (per_cnt_q + PLL_TOL >= nom);
    end
  end

  // ***********************************************************
  // Lockstep reset of the display core
  // ***********************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset_n_q <= 1'b0;
      core_start_q   <= 1'b0;
    end
    else
    begin
      core_reset_n_q <= hr_sync_q;
      core_start_q   <= hr_sync_q && !hr_prev_q;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  property p_follow;
    @(posedge clock) disable iff (!rst_n)
    fmt_change |=> (fmt_60_q == $past(meas_60));
  endproperty
  a_follow: assert property (p_follow)
    else $error("format did not follow measured rate");

  property p_geo60;
    @(posedge clock) disable iff (!rst_n)
    $past(fmt_60_q) |-> (h_active_q == H60 && v_active_q == V60);
  endproperty
  a_geo60: assert property (p_geo60)
    else $error("60 Hz geometry wrong");

  property p_geo50;
    @(posedge clock) disable iff (!rst_n)
    !$past(fmt_60_q) |-> (h_active_q == H50 && v_active_q == V50);
  endproperty
  a_geo50: assert property (p_geo50)
    else $error("50 Hz geometry wrong");

  property p_core_fast;
    @(posedge clock) disable iff (!rst_n)
    $changed(fmt_60_q) |-> ##[0:2] (core_rate_60_q == fmt_60_q);
  endproperty
  a_core_fast: assert property (p_core_fast)
    else $error("core rate late");

  property p_blank;
    @(posedge clock) disable iff (!rst_n)
    fmt_change |=> blank_q ##1 blank_q[*4];
  endproperty
  a_blank: assert property (p_blank)
    else $error("output not blanked after change");

  property p_pll;
    @(posedge clock) disable iff (!rst_n)
    (vs_edge && per_ok && per_cnt_q > nom + PLL_TOL)
      |=> (pll_dn_q && !pll_up_q && !pll_lock_q);
  endproperty
  a_pll: assert property (p_pll)
    else $error("loop steering wrong");

  property p_lockstep;
    @(posedge clock) disable iff (!rst_n)
    !hr_sync_q |=> !core_reset_n_q;
  endproperty
  a_lockstep: assert property (p_lockstep)
    else $error("core left reset with host in reset");

  property p_two_frames;
    @(posedge clock) disable iff (!rst_n)
    (vs_edge && (!cand_seen_q || cand_60_q != meas_60))
      |=> $stable(fmt_60_q);
  endproperty
  a_two_frames: assert property (p_two_frames)
    else $error("format moved on a single frame");

endmodule

`default_nettype wire

// [hw/frvmf_pkg.sv]
// Constants and types shared by the frame rate video mode follower
package frvmf_pkg;

  // ***********************************************************
  // Clock and timing
  // ***********************************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned HOST_CLK_KHZ  = 21_477;
  localparam int unsigned SWITCH_NS     = 10_000;
  localparam int unsigned SWITCH_CYC    = SWITCH_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MS      = 2_000;
  localparam int unsigned BLANK_CYC     = BLANK_MS * (CLK_HZ / 1_000);

  // ***********************************************************
  // Frame rates and frame period measurement
  // ***********************************************************
  localparam int unsigned RATE60_HZ = 60;
  localparam int unsigned RATE50_HZ = 50;
  localparam int unsigned PER_W     = 20;
  localparam logic [PER_W-1:0] PER60  = PER_W'(CLK_HZ / RATE60_HZ);
  localparam logic [PER_W-1:0] PER50  = PER_W'(CLK_HZ / RATE50_HZ);
  localparam logic [PER_W-1:0] PER_MID =
    PER_W'((CLK_HZ / RATE60_HZ + CLK_HZ / RATE50_HZ) / 2);
  localparam logic [PER_W-1:0] PER_MAX = 20'hFFFFF;
  localparam logic [PER_W-1:0] PER_MIN = PER_W'(CLK_HZ / 100);
  localparam logic [PER_W-1:0] PLL_TOL = 20'h00008;

  // ***********************************************************
  // Output format geometry
  // ***********************************************************
  localparam int unsigned GEO_W = 10;
  localparam logic [GEO_W-1:0] H60 = 10'h280;
  localparam logic [GEO_W-1:0] V60 = 10'h1E0;
  localparam logic [GEO_W-1:0] H50 = 10'h300;
  localparam logic [GEO_W-1:0] V50 = 10'h240;

  localparam int unsigned BLK_W = 25;

  typedef enum logic [1:0] {
    FRVMF_RST,
    FRVMF_RUN
  } frvmf_core_t;

endpackage

// [tb/frvmf_host_model.sv]
// Host computer model: frame sync pulses and system reset pin
`timescale 1ns/1ps
`default_nettype none

module frvmf_host_model
(
  input  wire logic clock,
  output logic      host_vsync,
  output logic      host_reset_n
);
  // ****
  // Sync pulse timing
  // ****
  int unsigned cyc  = 0;
  int unsigned last = 0;

  initial
  begin
    host_vsync   = 1'b0;
    host_reset_n = 1'b1;
  end

  // Pulse held four cycles so it survives the two-flop synchroniser
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (host_vsync && (cyc - last >= 4))
      host_vsync <= 1'b0;
  end

  // Rise gap cycles after the previous rise, or one edge after the call if the caller already waited that long
  task automatic frame(input int unsigned gap);
    @(posedge clock);
    while (cyc - last < gap)
      @(posedge clock);
    host_vsync <= 1'b1;
    last       <= cyc;
  endtask

  task automatic set_reset(input logic lvl);
    @(posedge clock);
    host_reset_n <= lvl;
  endtask
endmodule
`default_nettype wire

// [tb/test_frvmf_follower.sv]
// Self-checking testbench for the frame rate follower
`timescale 1ns/1ps
`default_nettype none

module test_frvmf_follower;
  import frvmf_pkg::*;

  // ****
  // Clock, reset and design
  // ****
  logic             clock = 1'b0;
  logic             rst_n = 1'b0;
  logic             host_vsync;
  logic             host_reset_n;
  logic             fmt_60_q;
  logic             core_rate_60_q;
  logic             core_reset_n_q;
  logic             core_start_q;
  logic             blank_q;
  logic             pll_up_q;
  logic             pll_dn_q;
  logic             pll_lock_q;
  logic [GEO_W-1:0] h_active_q;
  logic [GEO_W-1:0] v_active_q;
  int               fail_count = 0;
  int               n_tests    = 0;

  // Scaled frame periods keep the run short; ratios as in hardware
  localparam int unsigned G60  = 1000;
  localparam int unsigned G50  = 1200;
  localparam int unsigned GMIN = 600;
  localparam int unsigned GBAD = 300;

  always #50 clock = ~clock;

  // Short blank so the settle window fits the run
  frvmf_follower #(
    .BLANK_CYCLES(50),
    .PER60_CYC   (PER_W'(G60)),
    .PER50_CYC   (PER_W'(G50)),
    .PERMIN_CYC  (PER_W'(GMIN))
  ) i_frvmf_follower (
    .clock         (clock),
    .rst_n         (rst_n),
    .host_vsync    (host_vsync),
    .host_reset_n  (host_reset_n),
    .fmt_60_q      (fmt_60_q),
    .h_active_q    (h_active_q),
    .v_active_q    (v_active_q),
    .core_rate_60_q(core_rate_60_q),
    .core_reset_n_q(core_reset_n_q),
    .core_start_q  (core_start_q),
    .blank_q       (blank_q),
    .pll_up_q      (pll_up_q),
    .pll_dn_q      (pll_dn_q),
    .pll_lock_q    (pll_lock_q)
  );

  frvmf_host_model i_frvmf_host_model (
    .clock       (clock),
    .host_vsync  (host_vsync),
    .host_reset_n(host_reset_n)
  );

  // ****
  // Checking and closing
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded by the switch time; a miss ends the run
  task automatic wait_fmt(input logic exp);
    int i;
    for (i = 0; i < SWITCH_CYC && fmt_60_q !== exp; i++)
      @(posedge clock);
    check(fmt_60_q, exp);
    if (fmt_60_q !== exp)
      test_done();
  endtask

  // ****
  // Scenarios
  // ****
  task automatic slow_frames();
    i_frvmf_host_model.frame(10);
    i_frvmf_host_model.frame(G50);
    repeat (10) @(posedge clock);
    check(pll_dn_q, 1'b1);
    check(pll_up_q, 1'b0);
    check(fmt_60_q, 1'b1);
    i_frvmf_host_model.frame(GBAD);
    repeat (10) @(posedge clock);
    check(pll_dn_q, 1'b1);
    i_frvmf_host_model.frame(G50);
    repeat (100) @(posedge clock);
    check(fmt_60_q, 1'b1);
    i_frvmf_host_model.frame(G50);
    wait_fmt(1'b0);
    check(blank_q, 1'b1);
    @(posedge clock);
    check(core_rate_60_q, 1'b0);
    check(h_active_q, H50);
    check(v_active_q, V50);
    repeat (100) @(posedge clock);
    check(blank_q, 1'b0);
  endtask

  task automatic fast_frames();
    i_frvmf_host_model.frame(G60);
    repeat (10) @(posedge clock);
    check(pll_up_q, 1'b1);
    check(pll_lock_q, 1'b0);
    check(fmt_60_q, 1'b0);
    i_frvmf_host_model.frame(G60);
    wait_fmt(1'b1);
    check(blank_q, 1'b1);
    @(posedge clock);
    check(core_rate_60_q, 1'b1);
    check(h_active_q, H60);
    check(v_active_q, V60);
    i_frvmf_host_model.frame(G60);
    repeat (10) @(posedge clock);
    check(pll_lock_q, 1'b1);
    check({pll_up_q, pll_dn_q}, 2'b00);
  endtask

  task automatic host_reset();
    int i;
    i_frvmf_host_model.set_reset(1'b0);
    repeat (6) @(posedge clock);
    check(core_reset_n_q, 1'b0);
    i_frvmf_host_model.set_reset(1'b1);
    for (i = 0; i < 10 && core_start_q !== 1'b1; i++)
      @(posedge clock);
    check(core_start_q, 1'b1);
    @(posedge clock);
    check(core_start_q, 1'b0);
    check(core_reset_n_q, 1'b1);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    check(fmt_60_q, 1'b1);
    check(h_active_q, H60);
    check(blank_q, 1'b0);
    rst_n <= 1'b1;
    slow_frames();
    fast_frames();
    host_reset();
    test_done();
  end
endmodule
`default_nettype wire
